//--- include/gpp_map.svh
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// Register byte addresses
`define GPP_ADDR_LEVEL 6'h00
`define GPP_ADDR_DIR 6'h04
`define GPP_ADDR_SET 6'h08
`define GPP_ADDR_CLR 6'h0C
`define GPP_ADDR_RISE 6'h10
`define GPP_ADDR_FALL 6'h14
`define GPP_ADDR_EDGE 6'h18
`define GPP_ADDR_ALT 6'h1C
`define GPP_ADDR_IMASK 6'h20
`define GPP_ADDR_SLEEP 6'h24
`define GPP_ADDR_PWR 6'h28

// Field layout
`define GPP_NPINS 28
`define GPP_DIR_RESET 28'h0000000
`define GPP_ZERO28 28'h0000000
`define GPP_PWR_REQ_BIT 0
`define GPP_PWR_ASLEEP_BIT 1
`define GPP_PWR_WAKE_BIT 2

`endif

//--- include/gpp_pkg.sv
package gpp_pkg;
    typedef logic [27:0] gpp_pins_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gpp_bus_req_t;

    typedef struct packed {
        gpp_pins_t out;
        gpp_pins_t oe_n;
    } gpp_pad_drive_t;

    typedef enum logic [1:0] {
        GPP_AWAKE = 2'b00,
        GPP_ENTER = 2'b01,
        GPP_ASLEEP = 2'b11
    } gpp_power_t;
endpackage

//--- verilog/gpp_port.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "gpp_map.svh"
// How it works
// (RULE1) 28 pins, each input or output and an interrupt source.
// (RULE2) Reset makes every pin an input until software changes direction.
// (RULE3) Set and clear writes update a hidden output latch.
// (RULE4) Set/clear work in any direction; latch shows once pin is output.
// (RULE5) Level register reads real pin state at any time, outputs too.
// (RULE6) Separate rising and falling enables per pin, edges recorded.
// (RULE7) Edge status register readable by software.
// (RULE8) Edges raise interrupt and act as wake-up from sleep.
// (RULE9) Sleep entry loads latch from sleep-state register before sleep.
// (RULE10) After sleep the latch keeps sleep values until set or clear.
// (RULE11) Software still sets direction for alternate-function pins.
// (RULE12) Eight port registers: level, set, clear, dir, rise, fall, edge, alt.
// (RULE13) Only direction is reset; others need software initialisation. Code also resets mask, edge status and power state.
// (RULE14) Direction one is output, zero is input.
// (RULE15) Writing one to set drives high, to clear drives low; zero nothing.
// (RULE16) Bits 0..27 map to pins 0..27; level one means high.
// (RULE17) Edge bits stick until written one; inputs synchronised first.
module gpp_port
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Register port
    input wire logic [5:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Pins
    input wire gpp_pkg::gpp_pins_t i_pin,
    output gpp_pkg::gpp_pins_t o_pin,
    output gpp_pkg::gpp_pins_t o_pin_oe_n,
    // Alternate functions
    input wire gpp_pkg::gpp_pins_t i_alt_out,
    output gpp_pkg::gpp_pins_t o_alt_sel,
    // Power and interrupt
    input wire logic i_sleep_req,
    output logic o_asleep,
    output logic o_wake,
    output logic o_irq
);
    import gpp_pkg::*;

    // =========================================================
    // Reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // =========================================================
    // Registers
    gpp_pins_t pin_direction_reg;
    gpp_pins_t out_latch_reg;
    gpp_pins_t rising_edge_enable_reg;
    gpp_pins_t falling_edge_enable_reg;
    gpp_pins_t edge_status_reg;
    gpp_pins_t alt_select_reg;
    gpp_pins_t irq_mask_reg;
    gpp_pins_t sleep_output_state_reg;
    gpp_pins_t sync1_reg;
    gpp_pins_t sync2_reg;
    gpp_pins_t prev_reg;
    gpp_pins_t edge_hit;
    gpp_pins_t pin_level_reg;
    gpp_power_t power_reg;
    gpp_bus_req_t req;
    logic sleep_req_reg;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    function automatic logic wr_hit(input gpp_bus_req_t r,
                                    input logic [5:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // Direction, reset to all inputs; mask, edge status and power state are reset too
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            pin_direction_reg <= `GPP_DIR_RESET; // (RULE2) (RULE13)
        else if (wr_hit(req, `GPP_ADDR_DIR))
            pin_direction_reg <= req.wdata[27:0]; // (RULE14)
    end

    // Plain configuration; no reset, software must initialise
    always_ff @(posedge i_clock)
    begin
        if (wr_hit(req, `GPP_ADDR_RISE))
            rising_edge_enable_reg <= req.wdata[27:0]; // (RULE6)
        if (wr_hit(req, `GPP_ADDR_FALL))
            falling_edge_enable_reg <= req.wdata[27:0]; // (RULE6)
        if (wr_hit(req, `GPP_ADDR_ALT))
            alt_select_reg <= req.wdata[27:0];
        if (wr_hit(req, `GPP_ADDR_SLEEP))
            sleep_output_state_reg <= req.wdata[27:0];
    end

    // Mask is reset so the interrupt is quiet at start-up
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask_reg <= `GPP_ZERO28;
        else if (wr_hit(req, `GPP_ADDR_IMASK))
            irq_mask_reg <= req.wdata[27:0];
    end

    // =========================================================
    // Output latch
    // Latch has no reset; pins are inputs so it is never seen.
    always_ff @(posedge i_clock)
    begin
        if (power_reg == GPP_ENTER)
            out_latch_reg <= sleep_output_state_reg; // (RULE9)
        else
        begin
            // Set wins if both were written; only one per cycle anyway
            if (wr_hit(req, `GPP_ADDR_CLR))
                out_latch_reg <= out_latch_reg & ~req.wdata[27:0]; // (RULE15)
            if (wr_hit(req, `GPP_ADDR_SET))
                out_latch_reg <= out_latch_reg | req.wdata[27:0]; // (RULE3)
        end
    end

    // Set/clear act regardless of direction (RULE4)
    // Direction must be set even for alternate pins (RULE11)
    always_comb
    begin
        for (int i = 0; i < `GPP_NPINS; i++)
        begin
            o_pin[i] = alt_select_reg[i] ? i_alt_out[i] : out_latch_reg[i];
            o_pin_oe_n[i] = ~pin_direction_reg[i]; // (RULE1) (RULE16)
        end
    end
    assign o_alt_sel = alt_select_reg;

    // =========================================================
    // Input sync and edges
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= `GPP_ZERO28;
            sync2_reg <= `GPP_ZERO28;
            prev_reg <= `GPP_ZERO28;
        end
        else
        begin
            sync1_reg <= i_pin; // (RULE17)
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign pin_level_reg = sync2_reg; // (RULE5) (RULE16)

    assign edge_hit = (sync2_reg & ~prev_reg & rising_edge_enable_reg)
                    | (~sync2_reg & prev_reg & falling_edge_enable_reg);

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            edge_status_reg <= `GPP_ZERO28;
        else if (wr_hit(req, `GPP_ADDR_EDGE))
            edge_status_reg <= (edge_status_reg & ~req.wdata[27:0])
                             | edge_hit; // (RULE17)
        else
            edge_status_reg <= edge_status_reg | edge_hit; // (RULE6)
    end

    assign o_irq = |(edge_status_reg & irq_mask_reg); // (RULE8)

    // =========================================================
    // Sleep sequencing
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            sleep_req_reg <= 1'b0;
        else if (wr_hit(req, `GPP_ADDR_PWR))
            sleep_req_reg <= req.wdata[`GPP_PWR_REQ_BIT];
        else if (power_reg == GPP_ENTER)
            sleep_req_reg <= 1'b0;
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            power_reg <= GPP_AWAKE;
        else
        begin
            case (power_reg)
                GPP_AWAKE:
                    if (i_sleep_req || sleep_req_reg)
                        power_reg <= GPP_ENTER;
                GPP_ENTER:
                    power_reg <= GPP_ASLEEP;
                GPP_ASLEEP:
                    if (|(edge_status_reg | edge_hit))
                        power_reg <= GPP_AWAKE; // (RULE8) (RULE10)
                default:
                    power_reg <= GPP_AWAKE;
            endcase
        end
    end

    assign o_asleep = (power_reg == GPP_ASLEEP);
    assign o_wake = o_asleep && |(edge_status_reg | edge_hit);

    // =========================================================
    // Read port
    // Set and clear are write-only and read as zero (RULE12)
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_rdata <= 32'h00000000;
        else if (req.rd)
        begin
            case (req.addr)
                `GPP_ADDR_LEVEL: o_rdata <= {4'h0, pin_level_reg};
                `GPP_ADDR_DIR: o_rdata <= {4'h0, pin_direction_reg};
                `GPP_ADDR_RISE: o_rdata <= {4'h0, rising_edge_enable_reg};
                `GPP_ADDR_FALL: o_rdata <= {4'h0, falling_edge_enable_reg};
                `GPP_ADDR_EDGE: o_rdata <= {4'h0, edge_status_reg}; // (RULE7)
                `GPP_ADDR_ALT: o_rdata <= {4'h0, alt_select_reg};
                `GPP_ADDR_IMASK: o_rdata <= {4'h0, irq_mask_reg};
                `GPP_ADDR_SLEEP: o_rdata <= {4'h0, sleep_output_state_reg};
                `GPP_ADDR_PWR: o_rdata <= {29'h00000000, o_wake, o_asleep,
                                           sleep_req_reg};
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
            o_rdata <= 32'h00000000;
    end
endmodule // gpp_port

//--- testbench/gpp_port_properties.sv
`timescale 1ns/1ns
// ==========================================
// Port checker
module gpp_port_properties
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Register port
    input wire logic [5:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Pins and power
    input wire gpp_pkg::gpp_pins_t o_pin_oe_n,
    input wire gpp_pkg::gpp_pins_t o_alt_sel,
    input wire logic i_sleep_req,
    input wire logic o_asleep,
    input wire logic o_wake,
    input wire logic o_irq
);
    import gpp_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_enter;
        i_sleep_req && !o_asleep;
    endsequence
    sequence s_settle;
        !o_asleep ##1 o_asleep;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_rdata_top: assert property (i_rd |=> o_rdata[31:28] == 4'h0)
        else $error("unused read bits not zero");
    a_setclr_read: assert property (i_rd && i_addr[5:3] == 3'h1
        |=> o_rdata == 32'h0) else $error("hidden latch became readable");
    a_dir_drive: assert property (i_wr && i_addr == 6'h04
        |=> ~o_pin_oe_n == $past(i_wdata[27:0])) else $error("direction");
    a_dir_hold: assert property (!(i_wr && i_addr == 6'h04)
        |=> $stable(o_pin_oe_n)) else $error("direction moved alone");
    a_alt_sel: assert property (i_wr && i_addr == 6'h1C
        |=> o_alt_sel == $past(i_wdata[27:0])) else $error("alt select");
    a_sleep_entry: assert property (s_enter |=> s_settle)
        else $error("sleep entry sequence wrong");
    a_wake_asleep: assert property (o_wake |-> o_asleep)
        else $error("wake outside sleep");
    a_irq_masked: assert property (i_wr && i_addr == 6'h20
        && i_wdata[27:0] == 28'h0 |=> !o_irq) else $error("masked irq");
endmodule // gpp_port_properties

bind gpp_port gpp_port_properties gpp_port_properties_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pin_oe_n(o_pin_oe_n), .o_alt_sel(o_alt_sel),
    .i_sleep_req(i_sleep_req), .o_asleep(o_asleep), .o_wake(o_wake),
    .o_irq(o_irq));

//--- testbench/gpp_pins_model.sv
`timescale 1ns/1ns
// ==========================================
// Outside world on the pins
module gpp_pins_model
import gpp_pkg::*;
(
    // Pad side of the port
    input wire gpp_pkg::gpp_pins_t i_pin_out,
    input wire gpp_pkg::gpp_pins_t i_pin_oe_n,
    // Level seen where nothing drives
    input wire gpp_pkg::gpp_pins_t i_ext,
    output gpp_pkg::gpp_pins_t o_pin
);
    // Driven pins read back their own level
    assign o_pin = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_ext);
endmodule // gpp_pins_model

//--- testbench/gpp_port_bench.sv
`timescale 1ns/1ns
`include "gpp_map.svh"
// ==========================================
// Bench
module gpp_port_bench;
    import gpp_pkg::*;
    logic i_clock, i_reset_n, wr, rd, sreq, asleep, wake, irq;
    logic [5:0] addr;
    logic [31:0] wdata, rdata;
    gpp_pins_t pin, pout, poe_n, alt_out, alt_sel, ext;
    int n_fail, checked;
    gpp_port gpp_port_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pin(pin), .o_pin(pout), .o_pin_oe_n(poe_n),
        .i_alt_out(alt_out), .o_alt_sel(alt_sel), .i_sleep_req(sreq),
        .o_asleep(asleep), .o_wake(wake), .o_irq(irq));
    gpp_pins_model gpp_pins_model_i (.i_pin_out(pout), .i_pin_oe_n(poe_n),
        .i_ext(ext), .o_pin(pin));
    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic set_ext(input gpp_pins_t v);
        @(posedge i_clock);
        ext <= v;
        repeat (5) @(posedge i_clock);
    endtask
    task automatic wait_sleep(input logic want);
        for (int k = 0; k < 40 && asleep !== want; k++)
            @(posedge i_clock) #1;
        chk(32'(asleep), 32'(want));
        if (asleep !== want)
            print_verdict();
    endtask
    initial
    begin
        {i_reset_n, wr, rd, sreq} = 4'h0;
        {addr, wdata} = 38'h0;
        alt_out = 28'h0;
        ext = 28'hA5A5A80;
        repeat (16) @(posedge i_clock);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 chk(32'(poe_n), 32'hFFFFFFF);
        rd_reg(`GPP_ADDR_DIR, 32'h0);
        // Latch has no reset value, so software clears it first
        wr_reg(`GPP_ADDR_CLR, 32'hFFFFFFF);
        wr_reg(`GPP_ADDR_SET, 32'h0000005);
        wr_reg(`GPP_ADDR_CLR, 32'h0000001);
        wr_reg(`GPP_ADDR_SET, 32'h0000000);
        wr_reg(`GPP_ADDR_ALT, 32'h0);
        #1 chk(32'(poe_n), 32'hFFFFFFF);
        wr_reg(`GPP_ADDR_DIR, 32'h000000F);
        #1 chk(32'(pout[3:0]), 32'h4);
        repeat (3) @(posedge i_clock);
        rd_reg(`GPP_ADDR_LEVEL, 32'hA5A5A84);
        rd_reg(`GPP_ADDR_SET, 32'h0);
        rd_reg(6'h3C, 32'h0);
        wr_reg(`GPP_ADDR_RISE, 32'h0000010);
        wr_reg(`GPP_ADDR_FALL, 32'h0000020);
        wr_reg(`GPP_ADDR_IMASK, 32'hFFFFFFF);
        wr_reg(`GPP_ADDR_EDGE, 32'hFFFFFFF);
        rd_reg(`GPP_ADDR_EDGE, 32'h0);
        set_ext(28'hA5A5AB0);
        rd_reg(`GPP_ADDR_EDGE, 32'h10);
        chk(32'(irq), 32'h1);
        set_ext(28'hA5A5A80);
        rd_reg(`GPP_ADDR_EDGE, 32'h30);
        wr_reg(`GPP_ADDR_EDGE, 32'h10);
        rd_reg(`GPP_ADDR_EDGE, 32'h20);
        wr_reg(`GPP_ADDR_IMASK, 32'h0);
        #1 chk(32'(irq), 32'h0);
        wr_reg(`GPP_ADDR_SLEEP, 32'h0000009);
        wr_reg(`GPP_ADDR_EDGE, 32'hFFFFFFF);
        @(posedge i_clock);
        sreq <= 1'b1;
        @(posedge i_clock);
        sreq <= 1'b0;
        wait_sleep(1'b1);
        chk(32'(pout[3:0]), 32'h9);
        rd_reg(`GPP_ADDR_PWR, 32'h2);
        chk(32'(wake), 32'h0);
        set_ext(28'hA5A5A90);
        wait_sleep(1'b0);
        chk(32'(pout[3:0]), 32'h9);
        wr_reg(`GPP_ADDR_CLR, 32'h0000008);
        #1 chk(32'(pout[3:0]), 32'h1);
        // Direction kept by software for the alternate pin
        wr_reg(`GPP_ADDR_ALT, 32'h0000001);
        #1 chk(32'(pout[3:0]), 32'h0);
        rd_reg(`GPP_ADDR_ALT, 32'h1);
        wr_reg(`GPP_ADDR_DIR, 32'hFFFFFFF);
        #1 chk(32'(poe_n), 32'h0);
        print_verdict();
    end
endmodule // gpp_port_bench
